// ---- bench/rss_i2c_master.sv ----
// Purpose: Behavioural serial bus master that owns the clock line.
// Assumes: Bit period 400 ns; the data line is wired-AND with a pull-up.
// Notes: The clock stands high and still between frames.
`timescale 1ns/1ps
`default_nettype none
module rss_i2c_master (
  output logic scl,
  output logic sda_rel,
  input wire logic sda_line
);
  // Idle bus: both lines released to the pull-up level.
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // Start: data falls while the clock is high.
  task automatic start();
    #200 sda_rel = 1'b0;
    #200 scl = 1'b0;
  endtask : start

  // Stop: data rises while the clock is high.
  task automatic stop();
    #50 sda_rel = 1'b0;
    #150 scl = 1'b1;
    #200 sda_rel = 1'b1;
    #400;
  endtask : stop

  // Data moves only in the low phase and is read mid-high.
  task automatic bit_io(input logic b, output logic r);
    #50 sda_rel = b;
    #150 scl = 1'b1;
    #100 r = sda_line;
    #100 scl = 1'b0;
  endtask : bit_io

  // MSB first, then a ninth clock; all ones releases the line for reads.
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack);
  endtask : xfer
endmodule : rss_i2c_master
`default_nettype wire

// ---- bench/rss_sup_properties.sv ----
// Purpose: Port-level timing and protection checks for the supervisor.
// Assumes: Bench pins change just after mclk edges; OCP_CYCLES is handed on by the bind.
// Notes: Saturating counters hold the long delays, so each check keeps its exact figure.
`timescale 1ns/1ps
`default_nettype none
module rss_sup_chk
  import rss_pkg::*;
#(
  parameter int OCP_CYCLES = OCP_CYC_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic main_enable_pin,
  input wire logic buck1_enable_pin,
  input wire logic undervoltage,
  input wire logic thermal_trip,
  input wire logic [NCH-1:0] overcurrent_trip,
  input wire logic ldo_below_soft_start,
  input wire logic [NCH-1:0] above_85,
  input wire logic [NCH-1:0] serial_on,
  input wire logic [NCH-1:0] channel_on,
  input wire logic [NCH-1:0] discharge,
  input wire logic [NCH-1:0] buck1_power_good_vec_unused_guard,
  input wire logic comm_enabled,
  input wire logic fault_oe_n,
  input wire logic sda_out,
  input wire logic sda_oe_n
);
  logic [12:0] mh_r;
  logic [12:0] b1_r;
  logic [3:0] ml_r;
  logic [15:0] oc_r;
  logic oc_on;

  // The LDO timer only runs outside soft-start, so the mask must match the design's.
  assign oc_on = overcurrent_trip[CH_LDO] && !ldo_below_soft_start && main_enable_pin;

  // The three delay counters saturate so that a long run never wraps into a false match.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mh_r <= '0;
      b1_r <= '0;
      ml_r <= '0;
      oc_r <= '0;
    end else begin
      mh_r <= !main_enable_pin ? '0 : mh_r + {12'h0, mh_r != 13'h1FFF};
      b1_r <= !(buck1_enable_pin && comm_enabled) ? '0 : b1_r + {12'h0, b1_r != 13'h1FFF};
      ml_r <= main_enable_pin ? '0 : ml_r + {3'h0, ml_r != 4'hF};
      oc_r <= (oc_on && (channel_on[CH_LDO] || oc_r != '0)) ? oc_r + 16'h1 : '0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_comm_dly; $rose(comm_enabled) |-> mh_r >= 2600 && mh_r <= 4000; endproperty
  a_comm_dly: assert property (p_comm_dly) else $error("comm enable delay off");
  property p_comm_off; !main_enable_pin [*6] |-> !comm_enabled; endproperty
  a_comm_off: assert property (p_comm_off) else $error("comm on without main");
  property p_ch_dly; $rose(channel_on[0]) |-> b1_r >= 2995 || serial_on[0]; endproperty
  a_ch_dly: assert property (p_ch_dly) else $error("channel on too early");
  property p_dis; $fell(channel_on[0]) |-> discharge[0]; endproperty
  a_dis: assert property (p_dis) else $error("no discharge at turn-off");
  property p_pg_off; (channel_on == 3'h0) [*4] |-> buck1_power_good_vec_unused_guard == 3'h0;
  endproperty
  a_pg_off: assert property (p_pg_off) else $error("power good while off");
  property p_pg_on; (channel_on[0] && above_85[0]) [*5] |-> buck1_power_good_vec_unused_guard[0];
  endproperty
  a_pg_on: assert property (p_pg_on) else $error("power good missing");
  property p_ocp; oc_r == OCP_CYCLES + 8 |-> !fault_oe_n; endproperty
  a_ocp: assert property (p_ocp) else $error("overcurrent timer did not expire");
  property p_err_off; !fault_oe_n && !$past(fault_oe_n) |-> channel_on == 3'h0; endproperty
  a_err_off: assert property (p_err_off) else $error("channel on in error mode");
  property p_err_hold; $rose(fault_oe_n) |-> ml_r >= 1 && ml_r <= 8; endproperty
  a_err_hold: assert property (p_err_hold) else $error("error left without main cycle");
  property p_uvlo; undervoltage [*6] |-> channel_on == 3'h0 && $stable(fault_oe_n); endproperty
  a_uvlo: assert property (p_uvlo) else $error("undervoltage not handled");
  property p_sda; sda_out == 1'b0 && (comm_enabled || sda_oe_n); endproperty
  a_sda: assert property (p_sda) else $error("data line driven wrongly");
  property p_tsd;
    (thermal_trip && buck1_enable_pin && comm_enabled) [*5] |-> !fault_oe_n && channel_on == 3'h0;
  endproperty
  a_tsd: assert property (p_tsd) else $error("thermal trip ignored");

  // Main scenarios that the bench is expected to reach.
  c_err: cover property ($fell(fault_oe_n));
  c_ch: cover property ($rose(channel_on[0]));
  c_ack: cover property (comm_enabled && !sda_oe_n);
endmodule : rss_sup_chk

bind rss_supervisor rss_sup_chk #(.OCP_CYCLES(OCP_CYCLES)) rss_sup_chk_i (
  .mclk(mclk), .rst(rst), .main_enable_pin(main_enable_pin),
  .buck1_enable_pin(buck1_enable_pin), .undervoltage(undervoltage),
  .thermal_trip(thermal_trip), .overcurrent_trip(overcurrent_trip),
  .ldo_below_soft_start(ldo_below_soft_start), .above_85(above_85), .serial_on(serial_on),
  .channel_on(channel_on), .discharge(discharge),
  .buck1_power_good_vec_unused_guard(buck1_power_good_vec_unused_guard),
  .comm_enabled(comm_enabled), .fault_oe_n(fault_oe_n), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n)
);
`default_nettype wire

// ---- bench/rss_supervisor_tb_top.sv ----
// Purpose: Self-checking bench for the supervisor and its serial slave.
// Assumes: OCP_CYCLES is shortened to 50; serial on/off bits stay low.
// Notes: Each scenario task drives the block and judges the result itself.
`timescale 1ns/1ps
`default_nettype none
module rss_supervisor_tb_top;
  import rss_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic main_enable_pin = 1'b0, buck1_enable_pin = 1'b0, ldo_enable_pin = 1'b0;
  logic undervoltage = 1'b0, thermal_trip = 1'b0, ldo_below_soft_start = 1'b0;
  logic rx_ready = 1'b1;
  logic [2:0] overcurrent_trip = 3'h0, above_85 = 3'h0, above_75 = 3'h0;
  logic [2:0] serial_on = 3'h0; // Pins alone switch channels.
  logic [11:0] ss_setting = 12'h321;
  logic [7:0] rd_byte = 8'h00;
  logic [2:0] channel_on, discharge, current_limit, pg, soft_start_en;
  logic [11:0] ss_time;
  logic comm_enabled, fault_oe_n, sda_out, sda_oe_n, rx_valid;
  logic [FIFO_W-1:0] rx_data;
  logic [FIFO_W-1:0] rxq[$];
  wire logic scl, m_sda, sda_line;
  int failures = 0, n_tests = 0, cyc = 0;

  // Open-drain bus: either party pulling low wins.
  assign sda_line = m_sda & (sda_oe_n | sda_out);

  rss_supervisor #(.OCP_CYCLES(50)) rss_supervisor_i (
    .mclk(mclk), .rst(rst), .clk_en(1'b1), .main_enable_pin(main_enable_pin),
    .buck1_enable_pin(buck1_enable_pin), .buck2_enable_pin(1'b0),
    .ldo_enable_pin(ldo_enable_pin), .undervoltage(undervoltage),
    .thermal_trip(thermal_trip), .overcurrent_trip(overcurrent_trip),
    .ldo_below_soft_start(ldo_below_soft_start), .above_85(above_85),
    .above_75(above_75), .serial_on(serial_on), .ss_setting(ss_setting), .scl_in(scl),
    .sda_in(sda_line), .rd_byte(rd_byte), .rx_ready(rx_ready), .channel_on(channel_on),
    .discharge(discharge), .current_limit(current_limit),
    .buck1_power_good_vec_unused_guard(pg), .soft_start_en(soft_start_en),
    .ss_time(ss_time), .comm_enabled(comm_enabled), .fault_oe_n(fault_oe_n),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .rx_data(rx_data), .rx_valid(rx_valid)
  );
  rss_i2c_master rss_i2c_master_i (.scl(scl), .sda_rel(m_sda), .sda_line(sda_line));

  // Clock, and a cycle ceiling that cuts a hang short.
  initial begin
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (rx_valid === 1'b1 && rx_ready) rxq.push_back(rx_data);
    if (cyc == 40000) begin
      failures++;
      tally_and_finish();
    end
  end

  // Resume just after an edge so that drives never race the design's sampling.
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask : wt
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One byte from the master; exp is the level expected on the ninth clock.
  task automatic wr(input logic [7:0] b, input logic exp);
    logic [7:0] r;
    logic a;
    rss_i2c_master_i.xfer(b, 1'b1, r, a);
    chk(a, exp);
  endtask : wr

  task automatic t_power();
    main_enable_pin = 1'b1;
    wt(2500);
    chk(comm_enabled, 1'b0);
    chk(sda_oe_n, 1'b1);
    wt(200);
    chk(comm_enabled, 1'b1);
    thermal_trip = 1'b1;
    wt(10);
    chk(fault_oe_n, 1'b1);
    thermal_trip = 1'b0;
    $display("t_power done");
  endtask : t_power

  task automatic t_chan();
    buck1_enable_pin = 1'b1;
    ldo_enable_pin = 1'b1;
    wt(2990);
    chk(channel_on, 3'h0);
    wt(20);
    chk(channel_on, 3'h5);
    chk(discharge, 3'h2);
    chk(soft_start_en, 3'h5);
    ss_setting = 12'h000;
    wt(2);
    chk({ss_time[11:8], ss_time[3:0]}, 8'h31);
    above_85 = 3'h5;
    above_75 = 3'h5;
    wt(6);
    chk(pg, 3'h5);
    chk(soft_start_en, 3'h0);
    above_85 = 3'h0;
    wt(6);
    chk(pg, 3'h5);
    above_75 = 3'h4;
    wt(6);
    chk(pg, 3'h4);
    above_85 = 3'h5;
    above_75 = 3'h5;
    $display("t_chan done");
  endtask : t_chan

  task automatic t_i2c();
    logic [7:0] rb;
    logic ak;
    rd_byte = 8'hC3;
    rss_i2c_master_i.start();
    wr(8'h54, 1'b0);
    wr(8'hA5, 1'b0);
    wr(8'h3C, 1'b0);
    rss_i2c_master_i.stop();
    chk(rxq.size(), 16'h2);
    chk(rxq[0], 9'h1A5);
    chk(rxq[1], 9'h03C);
    rss_i2c_master_i.start();
    wr(8'h56, 1'b1);
    rss_i2c_master_i.stop();
    rss_i2c_master_i.start();
    wr(8'h55, 1'b0);
    rss_i2c_master_i.xfer(8'hFF, 1'b1, rb, ak);
    chk(rb, 8'hC3);
    rss_i2c_master_i.stop();
    chk(sda_oe_n, 1'b1);
    wt(1);
    rx_ready = 1'b0;
    rss_i2c_master_i.start();
    wr(8'h54, 1'b0);
    // A stalled reader fills 32 slots plus the output stage; the next byte is refused.
    for (int i = 0; i < 33; i++) wr(8'h11, 1'b0);
    wr(8'h22, 1'b1);
    rss_i2c_master_i.stop();
    wt(1);
    rx_ready = 1'b1;
    $display("t_i2c done");
  endtask : t_i2c

  task automatic t_uvlo();
    undervoltage = 1'b1;
    wt(10);
    chk(channel_on, 3'h0);
    chk(fault_oe_n, 1'b1);
    undervoltage = 1'b0;
    wt(3100);
    chk(channel_on, 3'h5);
    chk(rxq.size(), 16'h23);
    $display("t_uvlo done");
  endtask : t_uvlo

  task automatic t_ocp();
    overcurrent_trip = 3'h1;
    wt(6);
    chk(current_limit, 3'h1);
    wt(30);
    overcurrent_trip = 3'h0;
    ldo_below_soft_start = 1'b1;
    wt(10);
    chk({fault_oe_n, channel_on}, 4'hD);
    overcurrent_trip = 3'h4;
    wt(80);
    chk(fault_oe_n, 1'b1);
    ldo_below_soft_start = 1'b0;
    wt(60);
    chk({fault_oe_n, channel_on, discharge}, 7'h07);
    overcurrent_trip = 3'h0;
    wt(20);
    chk(fault_oe_n, 1'b0);
    main_enable_pin = 1'b0;
    wt(10);
    chk(fault_oe_n, 1'b1);
    $display("t_ocp done");
  endtask : t_ocp

  task automatic t_tsd();
    main_enable_pin = 1'b1;
    wt(5700);
    chk(channel_on, 3'h5);
    overcurrent_trip = 3'h1;
    wt(10);
    thermal_trip = 1'b1;
    wt(10);
    chk({fault_oe_n, channel_on}, 4'h0);
    thermal_trip = 1'b0;
    overcurrent_trip = 3'h0;
    $display("t_tsd done");
  endtask : t_tsd

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // Main sequence: reset for four cycles, then every scenario in turn.
  initial begin
    wt(4);
    rst = 1'b0;
    wt(2);
    t_power();
    t_chan();
    t_i2c();
    t_uvlo();
    t_ocp();
    t_tsd();
    tally_and_finish();
  end
endmodule : rss_supervisor_tb_top
`default_nettype wire

// ---- include/rss_pkg.sv ----
// Purpose: Shared constants and types for the regulator supervisor with serial slave.
// Assumes: mclk runs at 20 MHz; all times below are converted to mclk cycles here.
// Notes: Times are kept in microseconds as printed; cycle counts derive from them.
package rss_pkg;

  // Clock period in nanoseconds.
  localparam int MCLK_PERIOD_NS = 50;

  // Reference start-up time to communication enable (typical figure, max is 200 us).
  localparam int REF_START_US = 130;
  // Channel enable to internal channel-on time (typical figure, max is 250 us).
  localparam int CH_ON_US = 150;
  // Overcurrent timer interval.
  localparam int OCP_TIMER_US = 1000;

  // Converts microseconds to whole mclk cycles, never less than one.
  function automatic int rss_us_to_cyc(input int us);
    int c;
    c = (us * 1000) / MCLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : rss_us_to_cyc

  localparam int REF_CYC = rss_us_to_cyc(REF_START_US);
  localparam int CH_CYC = rss_us_to_cyc(CH_ON_US);
  localparam int OCP_CYC_DEF = rss_us_to_cyc(OCP_TIMER_US);

  // Counter widths.
  localparam int DLY_W = 12;
  localparam int OCP_W = 16;

  // Channel indices.
  localparam int NCH = 3;
  localparam int CH_B1 = 0;
  localparam int CH_B2 = 1;
  localparam int CH_LDO = 2;

  // Soft-start setting width per channel.
  localparam int SS_W = 4;

  // Serial byte handling.
  localparam int BYTE_W = 8;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BITS_TX_LAST = 4'h7;
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h2A; // Arbitrary default value.

  // Receive FIFO: one flag bit marking the first data byte, then the byte.
  localparam int FIFO_W = BYTE_W + 1;
  localparam int FIFO_D = 32;

  // Positions of the synchronised pin inputs.
  localparam int SY_MAIN = 0;
  localparam int SY_CH = 1;   // Three channel enable pins, 1..3.
  localparam int SY_UVLO = 4;
  localparam int SY_TSD = 5;
  localparam int SY_OC = 6;   // Three overcurrent trips, 6..8.
  localparam int SY_LSS = 9;
  localparam int SY_H85 = 10; // Three comparators, 10..12.
  localparam int SY_H75 = 13; // Three comparators, 13..15.
  localparam int SY_SCL = 16;
  localparam int SY_SDA = 17;
  localparam int SYN_W = 18;

  // Supervisor modes.
  typedef enum logic [1:0] {
    SV_STBY = 2'b00,
    SV_REFUP = 2'b01,
    SV_RUN = 2'b10,
    SV_ERR = 2'b11
  } rss_sv_t;

  // Serial slave states.
  typedef enum logic [2:0] {
    I2_IDLE = 3'b000,
    I2_RX = 3'b001,
    I2_ACK = 3'b010,
    I2_TX = 3'b011,
    I2_RACK = 3'b100,
    I2_WAIT = 3'b101
  } rss_i2_t;

endpackage : rss_pkg

// ---- include/rss_stream_if.sv ----
// Purpose: Valid/ready byte stream between the supervisor and its receive FIFO.
// Assumes: Both ends run on mclk.
// Notes: The source holds data while valid is high and ready is low.
`timescale 1ns/1ps
`default_nettype none
interface rss_stream_if #(parameter int W = 9);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : rss_stream_if
`default_nettype wire

// ---- verilog/rss_fifo.sv ----
// Purpose: Synchronous FIFO with a registered output stage.
// Assumes: Single clock, one writer and one reader.
// Notes: The output word and its valid come straight from flip-flops.
`timescale 1ns/1ps
`default_nettype none
module rss_fifo
  import rss_pkg::*;
#(
  parameter int WIDTH = FIFO_W,
  parameter int DEPTH = FIFO_D
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  rss_stream_if.snk wr,
  rss_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [WIDTH-1:0] dout;
    logic vout;
  } rss_fifo_st_t;

  rss_fifo_st_t s;
  rss_fifo_st_t n;
  logic push;
  logic pop;

  // Full is honest: the writer sees ready low once every slot holds a word.
  assign wr.ready = (s.cnt != (AW + 1)'(DEPTH));
  assign rd.data = s.dout;
  assign rd.valid = s.vout;
  assign push = wr.valid && wr.ready;
  assign pop = (s.cnt != '0) && (!s.vout || rd.ready);

  // Next state: refill the output stage whenever it is empty or being taken.
  always_comb begin
    n = s;
    if (rd.ready && s.vout) begin
      n.vout = 1'b0;
    end
    if (pop) begin
      n.dout = s.mem[s.rp];
      n.vout = 1'b1;
      n.rp = s.rp + AW'(1);
    end
    if (push) begin
      n.mem[s.wp] = wr.data;
      n.wp = s.wp + AW'(1);
    end
    n.cnt = s.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else if (clk_en) begin
      s <= n;
    end
  end

endmodule : rss_fifo
`default_nettype wire

// ---- verilog/rss_supervisor.sv ----
// Purpose: Regulator supervisor: channel sequencing, protection, power-good and serial slave.
// Assumes: Pins are asynchronous to mclk; serial on/off bits and soft-start settings
//   come from logic on mclk; rst is the power-on reset.
// Notes: Received bytes go to a FIFO; read data are supplied on rd_byte.
`timescale 1ns/1ps
`default_nettype none
module rss_supervisor
  import rss_pkg::*;
#(
  parameter int OCP_CYCLES = OCP_CYC_DEF,
  parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic main_enable_pin,
  input wire logic buck1_enable_pin,
  input wire logic buck2_enable_pin,
  input wire logic ldo_enable_pin,
  input wire logic undervoltage,
  input wire logic thermal_trip,
  input wire logic [NCH-1:0] overcurrent_trip,
  input wire logic ldo_below_soft_start,
  input wire logic [NCH-1:0] above_85,
  input wire logic [NCH-1:0] above_75,
  input wire logic [NCH-1:0] serial_on,
  input wire logic [NCH*SS_W-1:0] ss_setting,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [BYTE_W-1:0] rd_byte,
  input wire logic rx_ready,
  output logic [NCH-1:0] channel_on,
  output logic [NCH-1:0] discharge,
  output logic [NCH-1:0] current_limit,
  output logic [NCH-1:0] buck1_power_good_vec_unused_guard,
  output logic [NCH-1:0] soft_start_en,
  output logic [NCH*SS_W-1:0] ss_time,
  output logic comm_enabled,
  output logic fault_oe_n,
  output logic sda_out,
  output logic sda_oe_n,
  output logic [FIFO_W-1:0] rx_data,
  output logic rx_valid
);

  typedef struct packed {
    logic [SYN_W-1:0] s1;
    logic [SYN_W-1:0] s2;
    logic scl_d;
    logic sda_d;
    rss_sv_t sv;
    logic [DLY_W-1:0] ref_cnt;
    logic [NCH-1:0][DLY_W-1:0] on_cnt;
    logic [NCH-1:0][OCP_W-1:0] oc_cnt;
    logic [NCH-1:0] on;
    logic [NCH-1:0] dis;
    logic [NCH-1:0] pg;
    logic [NCH-1:0] ss_en;
    logic [NCH-1:0] ilim;
    logic [NCH-1:0][SS_W-1:0] ss_t;
    logic comm_en;
    logic fault_oe_n;
    rss_i2_t ist;
    logic [3:0] bitc;
    logic [BYTE_W-1:0] sh;
    logic addr_ph;
    logic rw;
    logic first;
    logic sda_o;
    logic sda_oe_n;
    logic push;
    logic [FIFO_W-1:0] pdata;
  } rss_st_t;

  rss_st_t s;
  rss_st_t n;
  rss_stream_if #(.W(FIFO_W)) fin ();
  rss_stream_if #(.W(FIFO_W)) fout ();

  logic [SYN_W-1:0] raw;
  logic main_s;
  logic uvlo_s;
  logic tsd_s;
  logic lss_s;
  logic scl_s;
  logic sda_s;
  logic [NCH-1:0] pin_s;
  logic [NCH-1:0] oc_s;
  logic [NCH-1:0] h85_s;
  logic [NCH-1:0] h75_s;
  logic [NCH-1:0] req;
  logic [NCH-1:0] oc_cond;
  logic [NCH-1:0] expire;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  // Counter helper shared by every delay and timer.
  function automatic logic [OCP_W-1:0] rss_inc(input logic [OCP_W-1:0] v);
    return v + OCP_W'(1);
  endfunction : rss_inc

  // Every pin passes two flip-flops; only the second stage is read below.
  assign raw = {sda_in, scl_in, above_75, above_85, ldo_below_soft_start, overcurrent_trip,
                thermal_trip, undervoltage, ldo_enable_pin, buck2_enable_pin,
                buck1_enable_pin, main_enable_pin};
  assign main_s = s.s2[SY_MAIN];
  assign pin_s = s.s2[SY_CH +: NCH];
  assign uvlo_s = s.s2[SY_UVLO];
  assign tsd_s = s.s2[SY_TSD];
  assign oc_s = s.s2[SY_OC +: NCH];
  assign lss_s = s.s2[SY_LSS];
  assign h85_s = s.s2[SY_H85 +: NCH];
  assign h75_s = s.s2[SY_H75 +: NCH];
  assign scl_s = s.s2[SY_SCL];
  assign sda_s = s.s2[SY_SDA];

  // Pin and serial control combine as in the priority table; both high counts as off.
  assign req = pin_s ^ serial_on;

  // Overcurrent condition per channel; the LDO ignores it in its soft-start region.
  always_comb begin
    oc_cond = s.on & oc_s;
    if (lss_s) begin
      oc_cond[CH_LDO] = 1'b0;
    end
    for (int i = 0; i < NCH; i++) begin
      expire[i] = oc_cond[i] && (s.oc_cnt[i] == OCP_W'(OCP_CYCLES - 1));
    end
  end

  // Serial line events, taken on the synchronised copies only.
  assign scl_rise = scl_s && !s.scl_d;
  assign scl_fall = !scl_s && s.scl_d;
  assign start_c = scl_s && s.scl_d && !sda_s && s.sda_d;
  assign stop_c = scl_s && s.scl_d && sda_s && !s.sda_d;

  assign fin.valid = s.push;
  assign fin.data = s.pdata;
  assign fout.ready = rx_ready;

  // All next-state logic: supervisor, channels, power-good and the serial slave.
  always_comb begin
    n = s;
    n.s1 = raw;
    n.s2 = s.s1;
    n.scl_d = scl_s;
    n.sda_d = sda_s;
    n.push = 1'b0;

    // Supervisor modes.
    case (s.sv)
      SV_STBY: begin
        if (main_s) begin
          n.sv = SV_REFUP;
          n.ref_cnt = '0;
        end
      end
      SV_REFUP: begin
        if (s.ref_cnt == DLY_W'(REF_CYC - 1)) begin
          n.sv = SV_RUN;
          n.comm_en = 1'b1;
        end else begin
          n.ref_cnt = DLY_W'(rss_inc(OCP_W'(s.ref_cnt)));
        end
      end
      SV_RUN: begin
        if (tsd_s && (|req)) begin
          n.sv = SV_ERR;
        end else if (|expire) begin
          n.sv = SV_ERR;
        end
      end
      SV_ERR: begin
        n.sv = SV_ERR; // Held until main drops or power-up.
      end
      default: begin
        n.sv = SV_STBY;
      end
    endcase

    // Main enable low always returns to standby; this is the only exit from error.
    if (!main_s) begin
      n.sv = SV_STBY;
      n.comm_en = 1'b0;
    end

    // Channel sequencing; anything other than a healthy run turns every channel off.
    if (n.sv != SV_RUN || (s.sv == SV_RUN && uvlo_s)) begin
      n.on = '0;
      n.on_cnt = '0;
      n.oc_cnt = '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (!req[i]) begin
          n.on[i] = 1'b0;
          n.on_cnt[i] = '0;
        end else if (!s.on[i]) begin
          // Restart after undervoltage uses the enables as they stand now.
          if (s.on_cnt[i] == DLY_W'(CH_CYC - 1)) begin
            n.on[i] = 1'b1;
            n.ss_t[i] = ss_setting[i*SS_W +: SS_W];
          end else begin
            n.on_cnt[i] = DLY_W'(rss_inc(OCP_W'(s.on_cnt[i])));
          end
        end
        // The timer only runs while the condition lasts.
        if (oc_cond[i]) begin
          n.oc_cnt[i] = rss_inc(s.oc_cnt[i]);
        end else begin
          n.oc_cnt[i] = '0;
        end
      end
    end

    // Discharge, current limit, soft-start and power-good per channel.
    for (int i = 0; i < NCH; i++) begin
      n.dis[i] = !n.on[i];
      n.ilim[i] = n.on[i] && oc_s[i];
      if (!n.on[i]) begin
        n.ss_en[i] = 1'b0;
        n.pg[i] = 1'b0;
      end else begin
        if (!s.on[i]) begin
          n.ss_en[i] = 1'b1;
        end else if (h85_s[i]) begin
          n.ss_en[i] = 1'b0;
        end
        if (h85_s[i]) begin
          n.pg[i] = 1'b1;
        end else if (!h75_s[i]) begin
          n.pg[i] = 1'b0;
        end
      end
    end
    // Undervoltage leaves the fault output alone; only the error mode pulls it.
    n.fault_oe_n = (n.sv != SV_ERR);

    // Serial slave; it never drives the clock and only ever pulls data low.
    n.sda_o = 1'b0;
    if (!n.comm_en) begin
      n.ist = I2_IDLE;
      n.sda_oe_n = 1'b1;
    end else if (start_c) begin
      n.ist = I2_RX;
      n.bitc = '0;
      n.addr_ph = 1'b1;
      n.sda_oe_n = 1'b1;
    end else if (stop_c) begin
      n.ist = I2_IDLE;
      n.sda_oe_n = 1'b1;
    end else begin
      case (s.ist)
        I2_IDLE: begin
          n.sda_oe_n = 1'b1;
        end
        I2_RX: begin
          if (scl_rise) begin
            n.sh = {s.sh[BYTE_W-2:0], sda_s};
            n.bitc = s.bitc + 4'h1;
          end else if (scl_fall && s.bitc == BITS_BYTE) begin
            // The acknowledge is put out in the low phase ahead of the ninth clock.
            n.bitc = '0;
            if (s.addr_ph) begin
              n.addr_ph = 1'b0;
              if (s.sh[BYTE_W-1:1] == SLAVE_ADDR) begin
                n.rw = s.sh[0];
                n.first = 1'b1;
                n.sda_oe_n = 1'b0;
                n.ist = I2_ACK;
              end else begin
                n.ist = I2_WAIT; // Foreign address, left unacknowledged.
              end
            end else if (fin.ready) begin
              n.push = 1'b1;
              n.pdata = {s.first, s.sh};
              n.first = 1'b0;
              n.sda_oe_n = 1'b0;
              n.ist = I2_ACK;
            end else begin
              n.ist = I2_WAIT; // A full FIFO refuses the byte.
            end
          end
        end
        I2_ACK: begin
          if (scl_fall) begin
            n.bitc = '0;
            if (s.rw) begin
              n.sh = rd_byte;
              n.sda_oe_n = rd_byte[BYTE_W-1];
              n.ist = I2_TX;
            end else begin
              n.sda_oe_n = 1'b1;
              n.ist = I2_RX;
            end
          end
        end
        I2_TX: begin
          if (scl_fall) begin
            if (s.bitc == BITS_TX_LAST) begin
              n.sda_oe_n = 1'b1;
              n.ist = I2_RACK;
            end else begin
              n.sh = {s.sh[BYTE_W-2:0], 1'b0};
              n.sda_oe_n = s.sh[BYTE_W-2];
              n.bitc = s.bitc + 4'h1;
            end
          end
        end
        I2_RACK: begin
          if (scl_rise) begin
            n.ist = sda_s ? I2_WAIT : I2_ACK;
          end
        end
        I2_WAIT: begin
          n.sda_oe_n = 1'b1;
        end
        default: begin
          n.ist = I2_IDLE;
          n.sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  // State register; reset holds the data and fault lines released.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.sda_oe_n <= 1'b1;
      s.fault_oe_n <= 1'b1;
    end else if (clk_en) begin
      s <= n;
    end
  end

  // Received bytes wait here; a stalled reader makes the slave refuse further bytes.
  rss_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_D)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .clk_en(clk_en),
    .wr(fin),
    .rd(fout)
  );

  // Outputs, each straight from a flip-flop.
  assign channel_on = s.on;
  assign discharge = s.dis;
  assign current_limit = s.ilim;
  assign buck1_power_good_vec_unused_guard = s.pg;
  assign soft_start_en = s.ss_en;
  assign ss_time = s.ss_t;
  assign comm_enabled = s.comm_en;
  assign fault_oe_n = s.fault_oe_n;
  assign sda_out = s.sda_o;
  assign sda_oe_n = s.sda_oe_n;
  assign rx_data = fout.data;
  assign rx_valid = fout.valid;

endmodule : rss_supervisor
`default_nettype wire
